// ===== include/bfl_pkg.sv
// package for the breaker failure timing block: constants, modes, condition codes
// assumes a 125 MHz sys_clk and a program cycle tick derived inside the block
//
// Summary of operation
// - block input latched once per program cycle
// - pick-up while unblocked: start and run timers
// - pick-up while blocked: blocked flag, no trips
// - block during start: release like pick-up drop
// - one pick-up starts both timers together
// - repeat-trip enable, default on, off clears timer and output
// - repeat-trip after delay, 5 ms steps, 100 ms
// - failure output after delay, 5 ms steps, 200 ms
// - condition value: normal/start/retrip/failure/blocked
// - current-only: current starts, trip relay ignored
// - current-only: outputs in turn, reset on drop
// - current-and-output: hold timers until relay operates
// - current-and-output: outputs while both persist
// - current-and-output: reset when either releases
// - current-or-output: either source starts timing
// - current-or-output: reset only when both released
// - current release below 97 % of threshold
// - mode selects current/signal/relay and/or combinations
package bfl_pkg;

  // program cycle tick, 5 ms step per tick
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_US = 5000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W = 20;

  // delay settings in ticks of 5 ms
  localparam int unsigned DLY_W = 19;
  localparam logic [18:0] RETRIP_DLY_RST = 19'h00014;
  localparam logic [18:0] FAIL_DLY_RST = 19'h00028;
  localparam logic RETRIP_EN_RST = 1'b1;

  // hysteresis: release at 97/100 of threshold
  localparam int unsigned HYST_NUM = 97;
  localparam int unsigned HYST_DEN = 100;

  // pick-up source selection
  typedef enum logic [3:0] {
    BFL_CUR_ONLY, BFL_DO_ONLY, BFL_SIG_ONLY, BFL_CUR_AND_DO, BFL_CUR_AND_SIG,
    BFL_CUR_OR_SIG, BFL_SIG_AND_DO, BFL_SIG_OR_DO, BFL_CUR_OR_DO,
    BFL_CUR_OR_SIG_AND_DO, BFL_CUR_OR_DO_OR_SIG, BFL_CUR_AND_DO_AND_SIG
  } bfl_mode_type;
  localparam logic [3:0] MODE_RST = 4'h0;

  // condition value
  typedef enum logic [2:0] {
    BFL_NORMAL, BFL_STARTED, BFL_RETRIP, BFL_FAILED, BFL_BLOCKED
  } bfl_cond_type;

endpackage

// ===== hw/bfl_current_pickup.sv
// one current comparator with 97 % release hysteresis
// assumes magnitudes and thresholds share one scale
`timescale 1ns/1ps
`default_nettype none
module bfl_current_pickup
  import bfl_pkg::*;
#(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic tick,
  // measurement and setting
  input wire logic [W-1:0] magnitude,
  input wire logic [W-1:0] threshold,
  // result
  output logic picked_r
);
  logic [W+7:0] mag_scaled;
  logic [W+7:0] thr_scaled;
  logic picked_nxt;

  always_comb begin
    mag_scaled = (W+8)'(magnitude) * (W+8)'(HYST_DEN);
    thr_scaled = (W+8)'(threshold) * (W+8)'(HYST_NUM);
    if (magnitude > threshold) begin
      picked_nxt = 1'b1;
    end else if (mag_scaled < thr_scaled) begin
      picked_nxt = 1'b0;
    end else begin
      picked_nxt = picked_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      picked_r <= 1'b0;
    end else if (clk_en && tick) begin
      picked_r <= picked_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== hw/bfl_timing.sv
// breaker failure timing logic top
// assumes all inputs synchronous to sys_clk; settings steady between ticks
`timescale 1ns/1ps
`default_nettype none
module bfl_timing
  import bfl_pkg::*;
#(
  parameter int unsigned PH_W = 16,
  parameter int unsigned PHASES = 3,
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // measurements
  input wire logic [PHASES*PH_W-1:0] phase_magnitude,
  input wire logic [PH_W-1:0] residual_magnitude,
  input wire logic residual_in_use,
  // settings
  input wire logic [PH_W-1:0] phase_pickup_threshold,
  input wire logic [PH_W-1:0] residual_pickup_threshold,
  input wire logic [3:0] mode_sel,
  input wire logic retrip_enable,
  input wire logic [DLY_W-1:0] repeat_trip_delay,
  input wire logic [DLY_W-1:0] failure_delay,
  // monitored sources
  input wire logic primary_trip_relay,
  input wire logic trip_signal,
  input wire logic block_in,
  // outputs
  output logic start_out,
  output logic blocked_out,
  output logic repeat_trip_out,
  output logic breaker_failure_output,
  output logic [2:0] condition,
  output logic tick_out
);
  logic rst_meta_r;
  logic rst_n;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;
  logic block_r;
  logic block_now;
  logic [PHASES:0] cur_pick;
  logic cur_any;
  logic pickup;
  bfl_mode_type mode;
  logic [DLY_W-1:0] retrip_cnt_r;
  logic [DLY_W-1:0] fail_cnt_r;
  logic start_r;
  logic blocked_r;
  logic retrip_r;
  logic fail_r;
  bfl_cond_type cond_r;
  bfl_cond_type cond_nxt;
  logic running;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // program cycle tick generator
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (clk_en) begin
      if (tick) begin
        tick_cnt_r <= '0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end
  assign tick = (tick_cnt_r == TICK_W'(TICK_LEN - 1));
  assign tick_out = tick;

  // block input latched at cycle start, held for the cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_r <= 1'b0;
    end else if (clk_en && tick) begin
      block_r <= block_in;
    end
  end

  // current comparators, one per phase plus residual
  genvar g;
  generate
    for (g = 0; g <= PHASES; g++) begin : g_pick
      logic [PH_W-1:0] mag;
      logic [PH_W-1:0] thr;
      if (g < PHASES) begin : g_ph
        assign mag = phase_magnitude[g*PH_W +: PH_W];
        assign thr = phase_pickup_threshold;
      end else begin : g_res
        assign mag = residual_in_use ? residual_magnitude : '0;
        assign thr = residual_pickup_threshold;
      end
      bfl_current_pickup #(.W(PH_W)) u_pick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .tick(tick),
        .magnitude(mag),
        .threshold(thr),
        .picked_r(cur_pick[g])
      );
    end
  endgenerate
  assign cur_any = |cur_pick;

  // pick-up combination by mode
  assign mode = bfl_mode_type'(mode_sel);
  always_comb begin
    case (mode)
      BFL_CUR_ONLY: pickup = cur_any;
      BFL_DO_ONLY: pickup = primary_trip_relay;
      BFL_SIG_ONLY: pickup = trip_signal;
      BFL_CUR_AND_DO: pickup = cur_any && primary_trip_relay;
      BFL_CUR_AND_SIG: pickup = cur_any && trip_signal;
      BFL_CUR_OR_SIG: pickup = cur_any || trip_signal;
      BFL_SIG_AND_DO: pickup = trip_signal && primary_trip_relay;
      BFL_SIG_OR_DO: pickup = trip_signal || primary_trip_relay;
      BFL_CUR_OR_DO: pickup = cur_any || primary_trip_relay;
      BFL_CUR_OR_SIG_AND_DO: pickup = cur_any || (trip_signal && primary_trip_relay);
      BFL_CUR_OR_DO_OR_SIG: pickup = cur_any || primary_trip_relay || trip_signal;
      BFL_CUR_AND_DO_AND_SIG: pickup = cur_any && primary_trip_relay && trip_signal;
      default: pickup = cur_any;
    endcase
  end

  // block value taken at this tick, held in block_r for the rest of the cycle
  assign block_now = tick ? block_in : block_r;

  // timers run only while picked up and unblocked
  assign running = pickup && !block_now;

  // start and blocked indications
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 1'b0;
      blocked_r <= 1'b0;
    end else if (clk_en && tick) begin
      start_r <= running;
      blocked_r <= pickup && block_now;
    end
  end

  // repeat-trip timer; both timers reset together on release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      retrip_cnt_r <= '0;
      retrip_r <= 1'b0;
    end else if (clk_en && tick) begin
      if (!running || !retrip_enable) begin
        retrip_cnt_r <= '0;
        retrip_r <= 1'b0;
      end else if (retrip_cnt_r >= repeat_trip_delay) begin
        retrip_r <= 1'b1;
      end else begin
        retrip_cnt_r <= retrip_cnt_r + 1'b1;
      end
    end
  end

  // breaker-failure timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_cnt_r <= '0;
      fail_r <= 1'b0;
    end else if (clk_en && tick) begin
      if (!running) begin
        fail_cnt_r <= '0;
        fail_r <= 1'b0;
      end else if (fail_cnt_r >= failure_delay) begin
        fail_r <= 1'b1;
      end else begin
        fail_cnt_r <= fail_cnt_r + 1'b1;
      end
    end
  end

  // condition value, highest stage wins
  always_comb begin
    if (fail_r) begin
      cond_nxt = BFL_FAILED;
    end else if (retrip_r) begin
      cond_nxt = BFL_RETRIP;
    end else if (start_r) begin
      cond_nxt = BFL_STARTED;
    end else if (blocked_r) begin
      cond_nxt = BFL_BLOCKED;
    end else begin
      cond_nxt = BFL_NORMAL;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_r <= BFL_NORMAL;
    end else if (clk_en) begin
      cond_r <= cond_nxt;
    end
  end

  assign start_out = start_r;
  assign blocked_out = blocked_r;
  assign repeat_trip_out = retrip_r;
  assign breaker_failure_output = fail_r;
  assign condition = cond_r;
endmodule
`default_nettype wire

// ===== bench/bfl_timing_props.sv
// checker for the breaker failure timing top
// assumes one clock domain, bound to every bfl_timing
`timescale 1ns/1ps
`default_nettype none
module bfl_timing_props
  import bfl_pkg::*;
#(
  parameter int unsigned TICK_LEN = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic block_in,
  input wire logic retrip_enable,
  input wire logic [DLY_W-1:0] repeat_trip_delay,
  input wire logic [DLY_W-1:0] failure_delay,
  input wire logic start_out,
  input wire logic blocked_out,
  input wire logic repeat_trip_out,
  input wire logic breaker_failure_output,
  input wire logic [2:0] condition,
  input wire logic tick_out
);
  logic [31:0] gap_r;
  logic seen_r;
  logic [DLY_W-1:0] run_r;
  logic [2:0] cond_r;
  logic en_tick;
  assign en_tick = clk_en && tick_out;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (clk_en) begin
      gap_r <= en_tick ? '0 : gap_r + 32'h1;
      seen_r <= seen_r | tick_out;
    end
  end
  // running ticks since start rose
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= '0;
    end else if (!start_out) begin
      run_r <= '0;
    end else if (en_tick) begin
      run_r <= run_r + 19'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cond_r <= 3'h0;
    else if (clk_en) cond_r <= breaker_failure_output ? 3'h3 : repeat_trip_out ? 3'h2 :
      start_out ? 3'h1 : blocked_out ? 3'h4 : 3'h0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_tick_gap: assert property (en_tick && seen_r |-> gap_r == TICK_LEN - 1)
    else $error("tick spacing wrong");
  chk_tick_only: assert property ($changed({start_out, blocked_out, repeat_trip_out,
    breaker_failure_output}) |-> $past(en_tick))
    else $error("output moved off a tick");
  chk_cond_lag: assert property (condition == cond_r)
    else $error("condition code wrong");
  chk_block_stop: assert property (en_tick && block_in |=> !start_out && !repeat_trip_out
    && !breaker_failure_output)
    else $error("trip while blocked");
  chk_blocked_flag: assert property (en_tick && !block_in |=> !blocked_out)
    else $error("blocked without block");
  chk_retrip_late: assert property ($rose(repeat_trip_out) |-> run_r == repeat_trip_delay)
    else $error("retrip at wrong tick");
  chk_fail_late: assert property ($rose(breaker_failure_output) |-> run_r == failure_delay)
    else $error("failure at wrong tick");
  chk_retrip_off: assert property (en_tick && !retrip_enable |=> !repeat_trip_out)
    else $error("retrip while disabled");
endmodule
bind bfl_timing bfl_timing_props #(.TICK_LEN(TICK_LEN)) u_props (.sys_clk(sys_clk),
  .arst_n(arst_n), .clk_en(clk_en), .block_in(block_in), .retrip_enable(retrip_enable),
  .repeat_trip_delay(repeat_trip_delay), .failure_delay(failure_delay),
  .start_out(start_out), .blocked_out(blocked_out), .repeat_trip_out(repeat_trip_out),
  .breaker_failure_output(breaker_failure_output), .condition(condition),
  .tick_out(tick_out));
`default_nettype wire

// ===== bench/bfl_partner.sv
// far side model: primary protection outputs and breaker coils
// assumes the bench drives fault at sys_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module bfl_partner (
  // clock
  input wire logic sys_clk,
  // bench commands
  input wire logic [1:0] fault,
  input wire logic slow,
  input wire logic clears,
  // breaker coils
  input wire logic retrip_coil,
  input wire logic fail_coil,
  // protection outputs
  output logic primary_trip_relay,
  output logic trip_signal
);
  logic [1:0] lag_r = 2'h0;
  logic open_r = 1'b0;
  logic [1:0] now;
  assign now = (slow ? lag_r : fault) & {2{!open_r}};
  assign primary_trip_relay = now[0];
  assign trip_signal = now[1];
  always_ff @(posedge sys_clk) lag_r <= fault;
  // an opened breaker ends the fault until it is removed
  always_ff @(posedge sys_clk) open_r <= (fault != 2'h0) &&
    (open_r || (clears && (retrip_coil || fail_coil)));
endmodule
`default_nettype wire

// ===== bench/tb_bfl_timing.sv
// self-checking bench for the breaker failure timing top
// assumes the partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_bfl_timing
  import bfl_pkg::*;
;
  logic sys_clk = 1'b0, arst_n = 1'b0, residual_in_use, retrip_enable, block_in, slow, clears;
  logic [47:0] phase_magnitude;
  logic [15:0] residual_magnitude, pthr, rthr;
  logic [3:0] mode_sel, outs, cp = 4'h0;
  logic [18:0] repeat_trip_delay, failure_delay;
  logic [1:0] fault;
  logic primary_trip_relay, trip_signal, start_out, blocked_out, repeat_trip_out;
  logic breaker_failure_output, tick_out, es, eb, er, ef, pk, cur;
  logic [2:0] condition;
  logic clk_en = 1'b1, ce = 1'b0;
  int checked = 0, mismatches = 0, seed = 64009, n = 0, pend = 0, rd, mg, th, m2, t2;
  assign outs = {start_out, blocked_out, repeat_trip_out, breaker_failure_output};
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) clk_en <= ({$random(seed)} % 4 != 0);
  bfl_timing #(.TICK_LEN(4)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .phase_magnitude(phase_magnitude), .residual_magnitude(residual_magnitude),
    .residual_in_use(residual_in_use), .phase_pickup_threshold(pthr),
    .residual_pickup_threshold(rthr), .mode_sel(mode_sel), .retrip_enable(retrip_enable),
    .repeat_trip_delay(repeat_trip_delay), .failure_delay(failure_delay),
    .primary_trip_relay(primary_trip_relay), .trip_signal(trip_signal), .block_in(block_in),
    .start_out(start_out), .blocked_out(blocked_out), .repeat_trip_out(repeat_trip_out),
    .breaker_failure_output(breaker_failure_output), .condition(condition),
    .tick_out(tick_out));
  bfl_partner far (.sys_clk(sys_clk), .fault(fault), .slow(slow), .clears(clears),
    .retrip_coil(repeat_trip_out), .fail_coil(breaker_failure_output),
    .primary_trip_relay(primary_trip_relay), .trip_signal(trip_signal));
  function automatic logic pick(input logic [3:0] m, input logic c, d, s);
    case (m)
      4'h1: return d;
      4'h2: return s;
      4'h3: return c & d;
      4'h4: return c & s;
      4'h5: return c | s;
      4'h6: return s & d;
      4'h7: return s | d;
      4'h8: return c | d;
      4'h9: return c | (s & d);
      4'ha: return c | d | s;
      4'hb: return c & d & s;
      default: return c;
    endcase
  endfunction
  task automatic cmp(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      while (!(tick_out === 1'b1 && clk_en === 1'b1)) @(posedge sys_clk);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // reference model, one step per tick
  always @(posedge sys_clk) begin
    ce = clk_en;
    if (tick_out === 1'b1 && clk_en === 1'b1) begin
      cur = |cp;
      pk = pick(mode_sel, cur, primary_trip_relay, trip_signal);
      for (int i = 0; i < 4; i++) begin
        m2 = (i < 3) ? phase_magnitude[i*16+:16] : (residual_in_use ? residual_magnitude : 0);
        t2 = (i < 3) ? pthr : rthr;
        if (m2 > t2) cp[i] = 1'b1;
        else if (m2 * 100 < t2 * 97) cp[i] = 1'b0;
      end
      eb = pk & block_in;
      n = (pk & !block_in) ? n + 1 : 0;
      es = n > 0;
      er = retrip_enable & (n > repeat_trip_delay);
      ef = n > failure_delay;
      pend = 2;
    end
  end
  always @(negedge sys_clk) begin
    if (pend == 2) begin
      cmp(outs, {es, eb, er, ef});
      pend = 1;
    end else if (pend == 1 && ce) begin
      cmp({1'b0, condition}, ef ? 4'h3 : er ? 4'h2 : es ? 4'h1 : eb ? 4'h4 : 4'h0);
      pend = 0;
    end
  end
  initial begin
    {residual_in_use, retrip_enable, block_in, slow, clears, fault, mode_sel} = '0;
    {phase_magnitude, residual_magnitude, pthr, rthr} = '0;
    repeat_trip_delay = 19'h14;
    failure_delay = 19'h28;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int r = 0; r < 40; r++) begin
      fault <= 2'h0;
      block_in <= 1'b0;
      phase_magnitude <= '0;
      residual_magnitude <= '0;
      tk(3);
      rd = 1 + {$random(seed)} % 3;
      th = 256 + {$random(seed)} % 3000;
      {slow, clears, residual_in_use, retrip_enable} <= 4'($random(seed));
      mode_sel <= 4'($random(seed));
      fault <= 2'($random(seed));
      repeat_trip_delay <= 19'(rd);
      failure_delay <= 19'(rd + 1 + {$random(seed)} % 3);
      pthr <= 16'(th);
      rthr <= 16'(th + 8);
      for (int k = 0; k < 10; k++) begin
        if ({$random(seed)} % 4 == 0) fault <= 2'($random(seed));
        block_in <= ({$random(seed)} % 8 == 0);
        for (int g = 0; g < 4; g++) begin
          mg = th - 40 + {$random(seed)} % 80;
          if (g < 3) phase_magnitude[g*16+:16] <= 16'(mg);
          else residual_magnitude <= 16'(mg);
        end
        tk(1);
      end
      $display("run %0d mode %0h done", r, mode_sel);
    end
    close_out();
  end
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
